// ---- src/twi_slave_map.svh ----
// constants for the two-wire register access slave
`ifndef TWI_SLAVE_MAP_SVH
`define TWI_SLAVE_MAP_SVH
`define SLV_ADDR7      7'h5d
`define DIR_BIT        0
`define PTR_W          8
`define REG_W          16
`define BYTE_BITS      4'h8
`define PTR_RESET      8'h00
`define REG_RESET      16'h0000
`endif

// ---- src/twi_slave_pkg.sv ----
// types for the two-wire register access slave
package twi_slave_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_PTR  = 3'b010,
    ST_WDAT = 3'b011,
    ST_RDAT = 3'b100,
    ST_RACK = 3'b101,
    ST_IGN  = 3'b110
  } phase_e;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } bus_ev_s;

  typedef struct packed {
    logic        we;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } reg_wr_s;
endpackage

// ---- src/reg_store.sv ----
// register memory for the two-wire slave, registered read data
`timescale 1ns/1ps
`include "twi_slave_map.svh"
module reg_store (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // write port
  input  wire twi_slave_pkg::reg_wr_s   wr,
  // read port
  input  wire logic [`PTR_W-1:0]        raddr,
  output logic      [`REG_W-1:0]        rdata_q
);
  logic [`REG_W-1:0] mem [0:255];

  // memory has no reset; contents undefined until written
  always_ff @(posedge clk) begin
    if (wr.we) begin
      mem[wr.addr] <= wr.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= `REG_RESET;
    end else begin
      rdata_q <= mem[raddr];
    end
  end
endmodule

// ---- src/line_sync.sv ----
// two-flop synchronisers and edge/condition detection on the serial lines
`timescale 1ns/1ps
module line_sync (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // serial lines
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  // detected events
  output twi_slave_pkg::bus_ev_s       ev_q
);
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_prev_q;
  logic       sda_prev_q;

  // idle lines are high, so the synchronisers reset high to avoid a false start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_q <= '0;
    end else begin
      ev_q.start <= scl_prev_q & scl_sync_q[1] & sda_prev_q & ~sda_sync_q[1];
      ev_q.stop  <= scl_prev_q & scl_sync_q[1] & ~sda_prev_q & sda_sync_q[1];
      ev_q.rise  <= ~scl_prev_q & scl_sync_q[1];
      ev_q.fall  <= scl_prev_q & ~scl_sync_q[1];
      ev_q.sda   <= sda_sync_q[1];
    end
  end
endmodule

// ---- src/twi_reg_slave.sv ----
// two-wire serial slave giving a bus master access to 16-bit registers
`timescale 1ns/1ps
`include "twi_slave_map.svh"
module twi_reg_slave (
  // clock and reset
  input  wire logic  CLK,
  input  wire logic  RST_N,
  // serial clock from the master, sampled only
  input  wire logic  SERIAL_CLOCK_IN,
  // serial data line, open drain
  input  wire logic  SERIAL_DATA_LINE_IN,
  output logic       SERIAL_DATA_LINE_OUT,
  output logic       SERIAL_DATA_LINE_OE,
  // status
  output logic       BUS_BUSY,
  output logic       REG_WRITE_PULSE
);
  twi_slave_pkg::bus_ev_s ev;
  twi_slave_pkg::phase_e  phase_q;
  twi_slave_pkg::reg_wr_s wr_d;
  logic [7:0]             sh_q;
  logic [3:0]             bit_q;
  logic                   ack_slot_q;
  logic                   pull_q;
  logic [`PTR_W-1:0]      ptr_q;
  logic                   hi_byte_q;
  logic [7:0]             upper_q;
  logic [`REG_W-1:0]      rdata;
  logic [7:0]             tx_q;
  logic                   busy_q;
  logic                   wpulse_q;
  logic                   ack_due_q;

  function automatic logic addr_hit(input logic [7:0] b);
    return b[7:1] == `SLV_ADDR7;
  endfunction

  line_sync u_sync (
    .clk    (CLK),
    .rst_n  (RST_N),
    .scl_in (SERIAL_CLOCK_IN),
    .sda_in (SERIAL_DATA_LINE_IN),
    .ev_q   (ev)
  );

  reg_store u_store (
    .clk     (CLK),
    .rst_n   (RST_N),
    .wr      (wr_d),
    .raddr   (ptr_q),
    .rdata_q (rdata)
  );

  logic byte_done;
  logic [7:0] rx_byte;
  assign byte_done = ev.rise & ~ack_slot_q & (bit_q == `BYTE_BITS - 4'h1);
  assign rx_byte   = {sh_q[6:0], ev.sda};

  // shift register and bit counter; msb first on receive
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sh_q       <= 8'h00;
      bit_q      <= 4'h0;
      ack_slot_q <= 1'b0;
    end else if (ev.start | ev.stop) begin
      bit_q      <= 4'h0;
      ack_slot_q <= 1'b0;
    end else if (ev.rise & ~ack_slot_q) begin
      sh_q  <= rx_byte;
      bit_q <= bit_q + 4'h1;
    end else if (ev.fall & (bit_q == `BYTE_BITS)) begin
      ack_slot_q <= 1'b1;
      bit_q      <= 4'h0;
    end else if (ev.fall & ack_slot_q) begin
      ack_slot_q <= 1'b0;
    end
  end

  // protocol phase
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      phase_q <= twi_slave_pkg::ST_IDLE;
    end else if (ev.stop) begin
      phase_q <= twi_slave_pkg::ST_IDLE;
    end else if (ev.start) begin
      phase_q <= twi_slave_pkg::ST_ADDR;
    end else begin
      unique case (phase_q)
        twi_slave_pkg::ST_IDLE: begin
        end
        twi_slave_pkg::ST_ADDR: begin
          if (byte_done) begin
            if (!addr_hit(rx_byte)) begin
              phase_q <= twi_slave_pkg::ST_IGN;
            end else if (rx_byte[`DIR_BIT]) begin
              phase_q <= twi_slave_pkg::ST_RDAT;
            end else begin
              phase_q <= twi_slave_pkg::ST_PTR;
            end
          end
        end
        twi_slave_pkg::ST_PTR: begin
          if (byte_done) begin
            phase_q <= twi_slave_pkg::ST_WDAT;
          end
        end
        twi_slave_pkg::ST_WDAT: begin
        end
        twi_slave_pkg::ST_RDAT: begin
          // the ack slot of the read address is ours, not the master's
          if (ev.fall & (bit_q == `BYTE_BITS) & ~ack_due_q) begin
            phase_q <= twi_slave_pkg::ST_RACK;
          end
        end
        twi_slave_pkg::ST_RACK: begin
          if (ev.rise) begin
            phase_q <= ev.sda ? twi_slave_pkg::ST_IGN : twi_slave_pkg::ST_RDAT;
          end
        end
        twi_slave_pkg::ST_IGN: begin
        end
        default: phase_q <= twi_slave_pkg::ST_IDLE;
      endcase
    end
  end

  // pointer, byte order and write assembly
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ptr_q     <= `PTR_RESET;
      hi_byte_q <= 1'b1;
      upper_q   <= 8'h00;
    end else if (ev.start | ev.stop) begin
      hi_byte_q <= 1'b1;
    end else if (byte_done & (phase_q == twi_slave_pkg::ST_PTR)) begin
      ptr_q     <= rx_byte;
      hi_byte_q <= 1'b1;
    end else if (byte_done & (phase_q == twi_slave_pkg::ST_WDAT)) begin
      if (hi_byte_q) begin
        upper_q <= rx_byte;
      end else begin
        ptr_q <= ptr_q + 8'h01;
      end
      hi_byte_q <= ~hi_byte_q;
    end else if (ev.rise & (phase_q == twi_slave_pkg::ST_RACK) & ~ev.sda) begin
      if (!hi_byte_q) begin
        ptr_q <= ptr_q + 8'h01;
      end
      hi_byte_q <= ~hi_byte_q;
    end
  end

  always_comb begin
    wr_d.we    = byte_done & (phase_q == twi_slave_pkg::ST_WDAT) & ~hi_byte_q;
    wr_d.addr  = ptr_q;
    wr_d.wdata = {upper_q, rx_byte};
  end

  // receiver acknowledge is decided on the eighth rise, before the phase moves on
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_due_q <= 1'b0;
    end else if (ev.start | ev.stop) begin
      ack_due_q <= 1'b0;
    end else if (byte_done) begin
      ack_due_q <= ((phase_q == twi_slave_pkg::ST_ADDR) & addr_hit(rx_byte)) |
                   (phase_q == twi_slave_pkg::ST_PTR) |
                   (phase_q == twi_slave_pkg::ST_WDAT);
    end
  end

  // read byte: loaded as the ack slot closes, upper half first
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_q <= 8'h00;
    end else if (ev.fall & ack_slot_q & (phase_q == twi_slave_pkg::ST_RDAT)) begin
      tx_q <= hi_byte_q ? rdata[15:8] : rdata[7:0];
    end else if (ev.fall & (phase_q == twi_slave_pkg::ST_RDAT)) begin
      tx_q <= {tx_q[6:0], 1'b1};
    end
  end

  // data line drive; changes on a clock falling edge, and clears on a start or stop
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pull_q <= 1'b0;
    end else if (ev.start | ev.stop) begin
      pull_q <= 1'b0;
    end else if (ev.fall) begin
      if (bit_q == `BYTE_BITS) begin
        // ack slot: acknowledge as receiver, release as transmitter
        pull_q <= ack_due_q;
      end else if ((phase_q == twi_slave_pkg::ST_RDAT) & ack_slot_q) begin
        // msb goes out straight from the store, the shifter loads on this same edge
        pull_q <= ~(hi_byte_q ? rdata[15] : rdata[7]);
      end else if (phase_q == twi_slave_pkg::ST_RDAT) begin
        pull_q <= ~tx_q[6];
      end else begin
        pull_q <= 1'b0;
      end
    end
  end

  // slave only: serial clock is never driven
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SERIAL_DATA_LINE_OE  <= 1'b0;
      SERIAL_DATA_LINE_OUT <= 1'b0;
    end else begin
      SERIAL_DATA_LINE_OE  <= pull_q;
      SERIAL_DATA_LINE_OUT <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_q   <= 1'b0;
      wpulse_q <= 1'b0;
    end else begin
      if (ev.start) begin
        busy_q <= 1'b1;
      end else if (ev.stop) begin
        busy_q <= 1'b0;
      end
      wpulse_q <= wr_d.we;
    end
  end

  assign BUS_BUSY        = busy_q;
  assign REG_WRITE_PULSE = wpulse_q;
endmodule

// ---- sim/twi_reg_slave_properties.sv ----
// port-level checks for the two-wire register access slave
`timescale 1ns/1ps
module twi_reg_slave_properties (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // serial lines
  input wire logic SERIAL_CLOCK_IN,
  input wire logic SERIAL_DATA_LINE_IN,
  input wire logic SERIAL_DATA_LINE_OUT,
  input wire logic SERIAL_DATA_LINE_OE,
  // status
  input wire logic BUS_BUSY,
  input wire logic REG_WRITE_PULSE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence start_seen;
    $fell(SERIAL_DATA_LINE_IN) && SERIAL_CLOCK_IN && $past(SERIAL_CLOCK_IN);
  endsequence
  sequence stop_seen;
    $rose(SERIAL_DATA_LINE_IN) && SERIAL_CLOCK_IN && $past(SERIAL_CLOCK_IN);
  endsequence
  a_out_low: assert property (SERIAL_DATA_LINE_OUT == 1'b0)
    else $error("data output not low");
  a_busy_start: assert property (start_seen |-> ##[1:8] BUS_BUSY)
    else $error("start not seen");
  a_busy_stop: assert property (stop_seen |-> ##[1:8] !BUS_BUSY)
    else $error("stop not seen");
  // the device may only move the line while the serial clock is low
  a_oe_scl_low: assert property ($changed(SERIAL_DATA_LINE_OE) |->
    !SERIAL_CLOCK_IN && !$past(SERIAL_CLOCK_IN, 2))
    else $error("data changed while clock high");
  a_pulse_once: assert property (REG_WRITE_PULSE |=> !REG_WRITE_PULSE)
    else $error("store pulse too long");
  a_pulse_ack: assert property (REG_WRITE_PULSE |-> ##[1:16] SERIAL_DATA_LINE_OE)
    else $error("stored byte not acknowledged");
  a_oe_busy: assert property (SERIAL_DATA_LINE_OE |-> BUS_BUSY)
    else $error("line pulled while idle");
  a_idle_quiet: assert property (!BUS_BUSY |-> !REG_WRITE_PULSE)
    else $error("store while idle");
endmodule
bind twi_reg_slave twi_reg_slave_properties u_twi_reg_slave_properties (
  .CLK(CLK), .RST_N(RST_N), .SERIAL_CLOCK_IN(SERIAL_CLOCK_IN),
  .SERIAL_DATA_LINE_IN(SERIAL_DATA_LINE_IN), .SERIAL_DATA_LINE_OUT(SERIAL_DATA_LINE_OUT),
  .SERIAL_DATA_LINE_OE(SERIAL_DATA_LINE_OE), .BUS_BUSY(BUS_BUSY),
  .REG_WRITE_PULSE(REG_WRITE_PULSE));

// ---- sim/twi_master_model.sv ----
// behavioural two-wire bus master
`timescale 1ns/1ps
module twi_master_model (
  // serial lines
  output logic     scl,
  output logic     sda_m,
  input wire logic sda
);
  // clock parks high between frames, line released
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // long low phase leaves room for the slave's sync latency
  task automatic put(input logic b, output logic r);
    #4 sda_m = b;
    #32 scl = 1'b1;
    #6 r = sda;
    #6 scl = 1'b0;
  endtask
  task automatic start();
    #4 sda_m = 1'b1;
    #20 scl = 1'b1;
    #24 sda_m = 1'b0;
    #24 scl = 1'b0;
  endtask
  task automatic stop();
    #4 sda_m = 1'b0;
    #20 scl = 1'b1;
    #24 sda_m = 1'b1;
    #24;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] rd,
                      output logic ak);
    for (int i = 7; i >= 0; i--) put(d[i], rd[i]);
    put(a, ak);
  endtask
endmodule

// ---- sim/tb_twi_reg_slave.sv ----
// self-checking bench for the two-wire register access slave
`timescale 1ns/1ps
`include "twi_slave_map.svh"
module tb_twi_reg_slave;
  logic        clk, rst_n, scl, sda_m, oe, out, busy, wpulse, ak;
  logic [7:0]  rd, p;
  logic [15:0] shadow [256];
  int          miscompares, n_checks, n_pulses;
  wire logic   sda = sda_m & ~oe;
  twi_reg_slave u_twi_reg_slave (.CLK(clk), .RST_N(rst_n), .SERIAL_CLOCK_IN(scl),
    .SERIAL_DATA_LINE_IN(sda), .SERIAL_DATA_LINE_OUT(out), .SERIAL_DATA_LINE_OE(oe),
    .BUS_BUSY(busy), .REG_WRITE_PULSE(wpulse));
  twi_master_model u_twi_master_model (.scl(scl), .sda_m(sda_m), .sda(sda));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] addr_byte(input logic dir);
    return {`SLV_ADDR7, dir};
  endfunction
  always @(posedge clk) if (wpulse === 1'b1) n_pulses++;
  task automatic send(input logic [7:0] d);
    u_twi_master_model.xfer(d, 1'b1, rd, ak);
    check("ack", 16'(ak), 16'h0000);
  endtask
  // a lone trailing upper byte is left open and ended by the next start
  task automatic wr(input logic [7:0] a, input int n, input bit part);
    int c0;
    logic [15:0] v;
    c0 = n_pulses;
    u_twi_master_model.start();
    send(addr_byte(1'b0));
    check("busy", 16'(busy), 16'h0001);
    send(a);
    for (int k = 0; k < n; k++) begin
      v = 16'($urandom);
      send(v[15:8]);
      send(v[7:0]);
      shadow[a + 8'(k)] = v;
    end
    if (part) send(8'($urandom));
    else u_twi_master_model.stop();
    check("stores", 16'(n_pulses - c0), 16'(n));
  endtask
  task automatic rdb(input logic [7:0] a, input int n);
    logic [15:0] v;
    u_twi_master_model.start();
    send(addr_byte(1'b0));
    send(a);
    u_twi_master_model.start();
    send(addr_byte(1'b1));
    for (int k = 0; k < n; k++) begin
      u_twi_master_model.xfer(8'hff, 1'b0, v[15:8], ak);
      u_twi_master_model.xfer(8'hff, k == n - 1, v[7:0], ak);
      check("read", v, shadow[a + 8'(k)]);
    end
    check("nack", 16'(ak), 16'h0001);
    #40 check("nack release", 16'(oe), 16'h0000);
    u_twi_master_model.stop();
    #40 check("idle", 16'(busy), 16'h0000);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #100us miscompares++;
    results();
  end
  initial begin
    rst_n = 1'b0;
    void'($urandom(32'hdfe3));
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1 check("reset", 16'({oe, out, busy, wpulse}), 16'h0000);
    // second pass crosses the top of the pointer range
    for (int t = 0; t < 4; t++) begin
      p = (t == 1) ? 8'hff : 8'($urandom);
      wr(p, 1 + t, t[0]);
      rdb(p, 1 + t);
    end
    u_twi_master_model.start();
    u_twi_master_model.xfer(8'hbc, 1'b1, rd, ak);
    check("foreign ack", 16'(ak), 16'h0001);
    u_twi_master_model.stop();
    results();
  end
endmodule
